/* core/gpw_pkg.sv */
package gpw_pkg;
	// ****************************************************
	// register offsets (byte addresses)
	// ****************************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00; // mode, enable, force
	localparam logic [7:0] OFS_RELOAD   = 8'h04; // countdown reload value
	localparam logic [7:0] OFS_ACT_EN   = 8'h08; // reload source enables
	localparam logic [7:0] OFS_WAKE_EN  = 8'h0c; // wake source enables
	localparam logic [7:0] OFS_LATCH    = 8'h10; // low-power latch nibble
	localparam logic [7:0] OFS_PORT     = 8'h14; // handler port write
	localparam logic [7:0] OFS_IO_RANGE = 8'h18; // base [15:0], mask [31:16]
	localparam logic [7:0] OFS_VECTOR   = 8'h1c; // two masked vectors
	localparam logic [7:0] OFS_STATUS   = 8'h20; // state and count

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int CTRL_MODE   = 0; // 1: interrupt-managed mode
	localparam int CTRL_ENABLE = 1; // timer and external entry enable
	localparam int CTRL_FORCE  = 3; // forced management interrupt
	localparam int ACT_IRQ     = 0;
	localparam int ACT_DMA     = 1;
	localparam int ACT_LOCAL   = 2;
	localparam int ACT_IO      = 3;
	localparam int ACT_EXT     = 4;
	localparam int ACT_KBD     = 5;
	localparam int ACT_VIDEO   = 6;
	localparam int ACT_DISK    = 7;
	localparam int ACT_VEC     = 8;
	localparam int ACT_W       = 9;
	localparam int VEC_EN_A    = 16;
	localparam int VEC_EN_B    = 17;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [3:0]       RST_CTRL    = 4'h0;
	localparam logic [15:0]      RST_RELOAD  = 16'h00ff;
	localparam logic [ACT_W-1:0] RST_ACT_EN  = 9'h1ff;
	localparam logic [ACT_W-1:0] RST_WAKE_EN = 9'h1ff;
	localparam logic [3:0]       RST_LATCH   = 4'h0;
	localparam logic [31:0]      RST_IO_RNG  = 32'h0000_0000;
	localparam logic [17:0]      RST_VECTOR  = 18'h00000;

	// ****************************************************
	// decode windows
	// ****************************************************
	localparam logic [15:0] KBD_DATA  = 16'h0060;
	localparam logic [15:0] KBD_CMD   = 16'h0064;
	localparam logic [15:0] VGA_LO    = 16'h03b0;
	localparam logic [15:0] VGA_HI    = 16'h03df;
	localparam logic [23:0] VMEM_LO   = 24'h0a0000;
	localparam logic [23:0] VMEM_HI   = 24'h0bffff;
	localparam logic [15:0] HD1_LO    = 16'h01f0;
	localparam logic [15:0] HD1_HI    = 16'h01f7;
	localparam logic [15:0] HD2_LO    = 16'h0170;
	localparam logic [15:0] HD2_HI    = 16'h0177;
	localparam logic [15:0] HD_ALT    = 16'h03f6;
	localparam logic [15:0] FDC_DATA  = 16'h03f5;
	localparam logic [23:0] VEC_TOP   = 24'h0003ff;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_HZ       = 25_000_000;
	localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
	localparam int T_TICK_US    = 1000;  // countdown step
	localparam int T_RESUME_MS  = 20;    // full speed before sync clock
	localparam int T_SMI_GAP_NS = 6000;  // back-to-back blocking
	localparam int T_SRST_NS    = 14000; // soft restart hold-off
	localparam int TICK_CYC     = CLK_MHZ * T_TICK_US;
	localparam int RESUME_CYC   = (CLK_HZ / 1000) * T_RESUME_MS;
	localparam int SMI_GAP_CYC  = (T_SMI_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int SRST_CYC     = (T_SRST_NS * CLK_MHZ + 999) / 1000;

	// ****************************************************
	// power states
	// ****************************************************
	typedef enum logic [4:0] {
		ST_NORMAL = 5'b00001,
		ST_CLKSW  = 5'b00010,
		ST_HWLOW  = 5'b00100,
		ST_SMI    = 5'b01000,
		ST_RESUME = 5'b10000
	} gpw_state_type;
endpackage

/* core/gpw_act_decode.sv */
// address traps that count as system activity
module gpw_act_decode (
	input  wire logic        cyc_valid,
	input  wire logic        cyc_io,
	input  wire logic        cyc_write,
	input  wire logic [23:0] cyc_addr,
	input  wire logic [31:0] io_rng,
	input  wire logic [17:0] vec_cfg,
	output logic      [4:0]  hit
);
	import gpw_pkg::*;

	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic in_io(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_io = (a >= lo) && (a <= hi);
	endfunction

	logic [15:0] ioa;    // io port address
	logic        io_cyc; // valid io cycle
	logic        mem_cyc;
	logic [7:0]  vec;    // vector number of a table fetch

	assign ioa     = cyc_addr[15:0];
	assign io_cyc  = cyc_valid & cyc_io;
	assign mem_cyc = cyc_valid & ~cyc_io;
	assign vec     = cyc_addr[9:2];

	// ****************************************************
	// trap decode
	// ****************************************************
	always_comb begin
		// either keyboard port is keyboard activity [R03]
		hit[0] = io_cyc & ((ioa == KBD_DATA) | (ioa == KBD_CMD));
		// graphics buffer or vga io range [R04]
		hit[1] = (mem_cyc & (cyc_addr >= VMEM_LO) & (cyc_addr <= VMEM_HI))
			| (io_cyc & in_io(ioa, VGA_LO, VGA_HI));
		// hard disk ranges, alternate port, floppy data [R05]
		hit[2] = io_cyc & (in_io(ioa, HD1_LO, HD1_HI) | in_io(ioa, HD2_LO, HD2_HI)
			| (ioa == HD_ALT) | (ioa == FDC_DATA));
		// one programmable range: masked bits are don't-care [R01]
		hit[3] = io_cyc & (((ioa ^ io_rng[15:0]) & ~io_rng[31:16]) == 16'h0000);
		// vector table read unless one of the two masked vectors [R06]
		hit[4] = mem_cyc & ~cyc_write & (cyc_addr <= VEC_TOP)
			& ~(vec_cfg[VEC_EN_A] & (vec == vec_cfg[7:0]))
			& ~(vec_cfg[VEC_EN_B] & (vec == vec_cfg[15:8]));
	end
endmodule

/* core/gpw_top.sv */
// Overview of operation
// [R01] enabled activity sources reload the countdown
// [R02] each reload source has its own enable
// [R03] keyboard port access counts as activity
// [R04] video memory or vga io is activity
// [R05] disk port ranges count as activity
// [R06] vector fetches count, two vectors maskable
// [R07] only enabled wake sources end low power
// [R08] full speed keeps all saving actions off
// [R09] expiry or external input enters hardware mode
// [R10] bus clock goes asynchronous first
// [R11] strobe with latch nibble on data in the same cycle
// [R12] resume strobe restores port defaults
// [R13] full speed interval before synchronous bus clock
// [R14] interrupt mode raises management interrupt
// [R15] acknowledge flushes cache, remaps segment three
// [R16] handler port writes forwarded to power port
// [R17] new interrupt blocked for gap time
// [R18] soft restart waits after acknowledge release
// [R19] interrupt mode needs cpu protocol support
// [R20] countdown reloads, expires once at zero
// [R21] one entry per expiry until wake
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module gpw_top #(
	parameter int unsigned TICK_CYC   = gpw_pkg::TICK_CYC,
	parameter int unsigned RESUME_CYC = gpw_pkg::RESUME_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] irq_req,
	input  wire logic [7:0]  dma_req,
	input  wire logic        local_device_claim_n,
	input  wire logic        local_master_request_n,
	input  wire logic        external_pm_event_in_n,
	input  wire logic        cyc_valid,
	input  wire logic        cyc_io,
	input  wire logic        cyc_write,
	input  wire logic [23:0] cyc_addr,
	input  wire logic        mgmt_active_ack_n,
	input  wire logic        soft_restart_req,
	output logic             mgmt_interrupt_req_n,
	output logic             cache_flush_n,
	output logic             mem_remap_smm,
	output logic             at_clk_async,
	output logic             power_port_strobe_n,
	output logic      [3:0]  system_data_low_nibble,
	output logic             system_data_oe,
	output logic             low_power_mode,
	output logic             soft_restart
);
	import gpw_pkg::*;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************************
	// declarations
	// ****************************************************
	logic [3:0]       ctrl_q;     // mode, enable, force
	logic [15:0]      reload_q;   // countdown reload value
	logic [ACT_W-1:0] act_en_q;   // reload enables
	logic [ACT_W-1:0] wake_en_q;  // wake enables
	logic [3:0]       latch_q;    // nibble sent on hardware entry
	logic [3:0]       port_q;     // nibble from handler writes
	logic             port_wr_q;  // handler write pending for the pins
	logic [31:0]      io_rng_q;
	logic [17:0]      vec_q;
	logic [31:0]      rdata_d;
	logic             hit_d;
	logic             setup;
	logic             wr_go;
	logic [4:0]       dec_hit;
	logic [ACT_W-1:0] act_q;      // registered activity events
	logic             ext_prev_n_q;
	logic             reload_evt;
	logic             wake_evt;
	logic [15:0]      tick_q;
	logic             tick;
	logic [15:0]      cnt_q;      // countdown value
	logic             expire_q;   // one-cycle expiry event
	logic             trig;
	logic             force_take;
	gpw_state_type    state_q;
	gpw_state_type    state_d;
	logic [19:0]      res_q;      // full speed interval counter
	logic             res_done;
	logic [7:0]       gap_q;      // blocking window after an interrupt
	logic             ack_prev_n_q;
	logic [8:0]       since_q;    // cycles since acknowledge removed
	logic             pend_q;     // soft restart waiting

	// ****************************************************
	// apb slave
	// ****************************************************
	assign setup = psel & ~penable;
	assign wr_go = psel & penable & pready & pwrite;

	// read mux; any other address answers with pslverr
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit_d   = 1'b1;
		case (paddr)
			OFS_CTRL:     rdata_d[3:0]  = ctrl_q;
			OFS_RELOAD:   rdata_d[15:0] = reload_q;
			OFS_ACT_EN:   rdata_d[8:0]  = act_en_q;
			OFS_WAKE_EN:  rdata_d[8:0]  = wake_en_q;
			OFS_LATCH:    rdata_d[3:0]  = latch_q;
			OFS_PORT:     rdata_d[3:0]  = port_q;
			OFS_IO_RANGE: rdata_d       = io_rng_q;
			OFS_VECTOR:   rdata_d[17:0] = vec_q;
			OFS_STATUS:   rdata_d = {cnt_q, 9'h000, pend_q, at_clk_async, state_q};
			default:      hit_d = 1'b0;
		endcase
	end

	// answer one cycle after setup: no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_d;
			if (setup && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

	// configuration writes; a write of the force bit beats its clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= RST_CTRL;
			reload_q  <= RST_RELOAD;
			act_en_q  <= RST_ACT_EN;
			wake_en_q <= RST_WAKE_EN;
			latch_q   <= RST_LATCH;
			port_q    <= RST_LATCH;
			io_rng_q  <= RST_IO_RNG;
			vec_q     <= RST_VECTOR;
		end else begin
			if (force_take) begin
				ctrl_q[CTRL_FORCE] <= 1'b0;
			end
			if (wr_go) begin
				case (paddr)
					OFS_CTRL:     ctrl_q    <= pwdata[3:0];
					OFS_RELOAD:   reload_q  <= pwdata[15:0];
					OFS_ACT_EN:   act_en_q  <= pwdata[8:0];
					OFS_WAKE_EN:  wake_en_q <= pwdata[8:0];
					OFS_LATCH:    latch_q   <= pwdata[3:0];
					OFS_PORT:     port_q    <= pwdata[3:0];
					OFS_IO_RANGE: io_rng_q  <= pwdata;
					OFS_VECTOR:   vec_q     <= pwdata[17:0];
					default:      ;
				endcase
			end
		end
	end

	// handler writes only reach the port while the cpu is in its handler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_wr_q <= 1'b0;
		end else begin
			port_wr_q <= wr_go & (paddr == OFS_PORT) & ~mgmt_active_ack_n; // [R16]
		end
	end

	// ****************************************************
	// activity detection
	// ****************************************************
	gpw_act_decode u_dec (
		.cyc_valid (cyc_valid),
		.cyc_io    (cyc_io),
		.cyc_write (cyc_write),
		.cyc_addr  (cyc_addr),
		.io_rng    (io_rng_q),
		.vec_cfg   (vec_q),
		.hit       (dec_hit)
	);

	// one event vector; external input is taken on its falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_q        <= '0;
			ext_prev_n_q <= 1'b1;
		end else begin
			ext_prev_n_q <= external_pm_event_in_n;
			act_q <= {dec_hit[4], dec_hit[2], dec_hit[1], dec_hit[0],
				~external_pm_event_in_n & ext_prev_n_q, dec_hit[3],
				~local_device_claim_n | ~local_master_request_n,
				|dma_req, |irq_req}; // [R01] [R03] [R04] [R05] [R06]
		end
	end

	assign reload_evt = |(act_q & act_en_q);  // [R01] [R02]
	assign wake_evt   = |(act_q & wake_en_q); // [R07]

	// ****************************************************
	// countdown timer
	// ****************************************************
	assign tick = (tick_q == 16'(TICK_CYC - 1));

	// step divider: one enable pulse per countdown step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 16'h0000;
		end else if (tick) begin
			tick_q <= 16'h0000;
		end else begin
			tick_q <= tick_q + 16'h0001;
		end
	end

	// a zero reload value never expires; that disables the timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= RST_RELOAD;
			expire_q <= 1'b0;
		end else begin
			expire_q <= tick & (cnt_q == 16'h0001) & ~reload_evt; // [R20]
			if (reload_evt || (state_q == ST_RESUME && res_done)) begin
				cnt_q <= reload_q; // [R20]
			end else if (tick && cnt_q != 16'h0000) begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	// ****************************************************
	// power state machine
	// ****************************************************
	assign trig       = ctrl_q[CTRL_ENABLE] & (expire_q | act_q[ACT_EXT]); // [R09] [R14]
	assign force_take = (state_q == ST_NORMAL) & ctrl_q[CTRL_MODE]
		& ctrl_q[CTRL_FORCE] & (gap_q == 8'h00);
	assign res_done   = (res_q == 20'(RESUME_CYC - 1));

	// triggers count only in full speed, so one expiry gives one entry
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_NORMAL: begin
				// interrupt mode is for cpus with the protocol [R19]
				if (ctrl_q[CTRL_MODE]) begin
					if ((trig || ctrl_q[CTRL_FORCE]) && gap_q == 8'h00) begin
						state_d = ST_SMI; // [R14] [R17] [R21]
					end
				end else if (trig) begin
					state_d = ST_CLKSW; // [R09] [R21]
				end
			end
			ST_CLKSW:  state_d = ST_HWLOW;
			ST_HWLOW: begin
				if (wake_evt) begin
					state_d = ST_RESUME; // [R07]
				end
			end
			ST_SMI: begin
				if (mgmt_interrupt_req_n && wake_evt) begin
					state_d = ST_RESUME; // [R07]
				end
			end
			ST_RESUME: begin
				if (res_done) begin
					state_d = ST_NORMAL; // [R13]
				end
			end
			default:   state_d = ST_NORMAL;
		endcase
	end

	// state register and full speed interval counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_NORMAL;
			res_q   <= 20'h00000;
		end else begin
			state_q <= state_d;
			res_q   <= (state_q == ST_RESUME) ? res_q + 20'h00001 : 20'h00000;
		end
	end

	// bus clock: asynchronous on any entry, synchronous after the interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			at_clk_async   <= 1'b0;
			low_power_mode <= 1'b0;
		end else begin
			low_power_mode <= (state_d != ST_NORMAL) && (state_d != ST_RESUME); // [R08]
			if (state_q == ST_NORMAL && state_d != ST_NORMAL) begin
				at_clk_async <= 1'b1; // [R10]
			end else if (state_q == ST_RESUME && res_done) begin
				at_clk_async <= 1'b0; // [R13]
			end
		end
	end

	// ****************************************************
	// power port pins
	// ****************************************************
	// data is driven only in the strobe cycle to keep the bus free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_port_strobe_n    <= 1'b1;
			system_data_low_nibble <= 4'h0;
			system_data_oe         <= 1'b0;
		end else begin
			power_port_strobe_n <= 1'b1;
			system_data_oe      <= 1'b0;
			if (state_q == ST_CLKSW) begin
				power_port_strobe_n    <= 1'b0; // [R11]
				system_data_low_nibble <= latch_q;
				system_data_oe         <= 1'b1;
			end else if (state_q == ST_HWLOW && state_d == ST_RESUME) begin
				power_port_strobe_n <= 1'b0; // [R12]
			end else if (port_wr_q) begin
				power_port_strobe_n    <= 1'b0; // [R16]
				system_data_low_nibble <= port_q;
				system_data_oe         <= 1'b1;
			end
		end
	end

	// ****************************************************
	// management interrupt and handler support
	// ****************************************************
	// request held until acknowledged, then the gap window starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mgmt_interrupt_req_n <= 1'b1;
			gap_q                <= 8'h00;
		end else begin
			if (state_q == ST_NORMAL && state_d == ST_SMI) begin
				mgmt_interrupt_req_n <= 1'b0; // [R14]
			end else if (!mgmt_interrupt_req_n && !mgmt_active_ack_n) begin
				mgmt_interrupt_req_n <= 1'b1;
			end
			if (!mgmt_interrupt_req_n && !mgmt_active_ack_n) begin
				gap_q <= 8'(SMI_GAP_CYC); // [R17]
			end else if (gap_q != 8'h00) begin
				gap_q <= gap_q - 8'h01;
			end
		end
	end

	// flush pulse on acknowledge, segment remap while it stays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_prev_n_q  <= 1'b1;
			cache_flush_n <= 1'b1;
			mem_remap_smm <= 1'b0;
		end else begin
			ack_prev_n_q  <= mgmt_active_ack_n;
			cache_flush_n <= ~(ack_prev_n_q & ~mgmt_active_ack_n); // [R15]
			mem_remap_smm <= ~mgmt_active_ack_n; // [R15]
		end
	end

	// soft restart held off until the window after acknowledge passes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q      <= 9'(SRST_CYC);
			pend_q       <= 1'b0;
			soft_restart <= 1'b0;
		end else begin
			if (!mgmt_active_ack_n) begin
				since_q <= 9'h000;
			end else if (since_q != 9'(SRST_CYC)) begin
				since_q <= since_q + 9'h001;
			end
			soft_restart <= pend_q & mgmt_active_ack_n & (since_q == 9'(SRST_CYC)); // [R18]
			if (soft_restart_req) begin
				pend_q <= 1'b1;
			end else if (soft_restart) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	a_normal_quiet: assert property (state_q == ST_NORMAL && $past(state_q) == ST_NORMAL
		|-> mgmt_interrupt_req_n && !low_power_mode && !at_clk_async) // [R08]
		else $error("power saving active at full speed");
	a_wake_gate: assert property (state_q == ST_HWLOW && !wake_evt
		|=> state_q == ST_HWLOW) // [R07]
		else $error("left low power without enabled wake");
	a_hw_entry: assert property (state_q == ST_NORMAL && !ctrl_q[CTRL_MODE]
		&& ctrl_q[CTRL_ENABLE] && expire_q |=> state_q == ST_CLKSW) // [R09]
		else $error("expiry did not enter hardware mode");
	a_clock_first: assert property (state_q == ST_NORMAL && state_d == ST_CLKSW
		|=> at_clk_async && power_port_strobe_n ##1 !power_port_strobe_n) // [R10]
		else $error("strobe before bus clock switch");
	a_latch_drive: assert property (state_q == ST_CLKSW |=> !power_port_strobe_n
		&& system_data_oe && system_data_low_nibble == $past(latch_q)) // [R11]
		else $error("latch nibble not driven with strobe");
	a_resume_hold: assert property ($rose(state_q == ST_RESUME)
		|-> at_clk_async [*8]) // [R13]
		else $error("bus clock resynced too early");
	a_resume_end: assert property (state_q == ST_RESUME && res_done
		|=> state_q == ST_NORMAL && !at_clk_async) // [R13]
		else $error("resume interval end missed");
	a_smi_raise: assert property (state_q == ST_NORMAL && state_d == ST_SMI
		|=> !mgmt_interrupt_req_n ##1 low_power_mode) // [R14]
		else $error("management interrupt not raised");
	a_flush_ack: assert property ($fell(mgmt_active_ack_n)
		|=> !cache_flush_n && mem_remap_smm ##1 cache_flush_n) // [R15]
		else $error("flush or remap missing on acknowledge");
	a_port_fwd: assert property (port_wr_q && state_q != ST_CLKSW && state_q != ST_HWLOW
		|=> !power_port_strobe_n && system_data_low_nibble == $past(port_q)) // [R16]
		else $error("handler port write not forwarded");
	a_smi_gap: assert property (gap_q != 8'h00 && state_q == ST_NORMAL
		|=> state_q != ST_SMI) // [R17]
		else $error("interrupt retriggered inside gap");
	a_srst_delay: assert property (soft_restart
		|-> $past(since_q) == 9'(SRST_CYC) && $past(mgmt_active_ack_n)) // [R18]
		else $error("soft restart not held off");
	a_reload_val: assert property (reload_evt |=> cnt_q == $past(reload_q)) // [R20]
		else $error("reload value not restored");
	a_expire_zero: assert property (expire_q |-> cnt_q == 16'h0000 ##1 !expire_q) // [R20] [R21]
		else $error("expiry not single at zero");

	c_hw_cycle: cover property (state_q == ST_HWLOW ##[1:1000] state_q == ST_RESUME);
	c_smi_cycle: cover property ($fell(mgmt_interrupt_req_n) ##[1:200] $fell(cache_flush_n));
	c_port_write: cover property (port_wr_q ##1 !power_port_strobe_n);
	c_soft_restart: cover property (pend_q ##[1:400] soft_restart);
endmodule

/* bench/gpw_partner.sv */
// cpu and power port latch facing the block
module gpw_partner #(
	parameter logic [3:0] DFLT = 4'hf // port outputs after a resume
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       req_n,
	input  wire logic       lp,
	input  wire logic       strobe_n,
	input  wire logic       oe,
	input  wire logic [3:0] nib,
	output logic            ack_n,
	output logic      [3:0] port_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] seen_q; // request age, gives a slow acknowledge
	// ****************************************************
	// cpu: ack three cycles after request, held until resume
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 2'b00;
			ack_n  <= 1'b1;
		end else begin
			seen_q <= {seen_q[0], !req_n};
			if (seen_q[1]) begin
				ack_n <= 1'b0;
			end else if (!lp) begin
				ack_n <= 1'b1;
			end
		end
	end
	// bare strobe means resume, so defaults come back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_q <= DFLT;
		end else if (!strobe_n) begin
			port_q <= oe ? nib : DFLT;
		end
	end
endmodule

/* bench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpw_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic [7:0] paddr, dma_req;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [15:0] irq_req;
	logic local_device_claim_n, local_master_request_n, external_pm_event_in_n;
	logic cyc_valid, cyc_io, cyc_write, mgmt_active_ack_n, soft_restart_req;
	logic mgmt_interrupt_req_n, cache_flush_n, mem_remap_smm, at_clk_async;
	logic power_port_strobe_n, system_data_oe, low_power_mode, soft_restart;
	logic [23:0] cyc_addr;
	logic [3:0] system_data_low_nibble, port_q, nib;
	int err_count, num_checks, n;
	gpw_top #(.TICK_CYC(4), .RESUME_CYC(20)) gpw_top_inst (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
		.dma_req(dma_req), .local_device_claim_n(local_device_claim_n),
		.local_master_request_n(local_master_request_n),
		.external_pm_event_in_n(external_pm_event_in_n), .cyc_valid(cyc_valid),
		.cyc_io(cyc_io), .cyc_write(cyc_write), .cyc_addr(cyc_addr),
		.mgmt_active_ack_n(mgmt_active_ack_n), .soft_restart_req(soft_restart_req),
		.mgmt_interrupt_req_n(mgmt_interrupt_req_n), .cache_flush_n(cache_flush_n),
		.mem_remap_smm(mem_remap_smm), .at_clk_async(at_clk_async),
		.power_port_strobe_n(power_port_strobe_n),
		.system_data_low_nibble(system_data_low_nibble), .system_data_oe(system_data_oe),
		.low_power_mode(low_power_mode), .soft_restart(soft_restart));
	gpw_partner gpw_partner_inst (.pclk(pclk), .presetn(presetn),
		.req_n(mgmt_interrupt_req_n), .lp(low_power_mode),
		.strobe_n(power_port_strobe_n), .oe(system_data_oe),
		.nib(system_data_low_nibble), .ack_n(mgmt_active_ack_n), .port_q(port_q));
	// xorshift keeps every run the same
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
			err_count++;
		end
	endtask
	// apb cycle, waits on pready, not on a cycle count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// one cpu io cycle, then time for the state to move
	task cyc(input logic [23:0] a);
		cyc_valid <= 1;
		cyc_io <= 1;
		cyc_addr <= a;
		cyc_write <= seed[0];
		@(posedge pclk) cyc_valid <= 0;
		repeat (3) @(posedge pclk);
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		test_done;
	end
	initial begin
		seed = 32'h51;
		{presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
		{irq_req, dma_req, cyc_valid, cyc_io, cyc_write, cyc_addr} = 51'h0;
		{local_device_claim_n, local_master_request_n, external_pm_event_in_n} = 3'h7;
		soft_restart_req = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, OFS_STATUS, 0);
		chk("state", 1, {27'h0, rd[4:0]});
		apb(0, 8'h24, 0);
		chk("slverr", 1, se);
		rd = xs();
		nib = rd[3:0];
		apb(1, OFS_LATCH, {28'h0, nib});
		apb(1, OFS_RELOAD, 2);
		apb(1, OFS_CTRL, 2);
		irq_req <= 16'h1;
		@(posedge pclk) irq_req <= 0;
		for (n = 0; n < 99 && low_power_mode !== 1; n++) @(posedge pclk);
		chk("async", 1, at_clk_async);
		for (n = 0; n < 9 && port_q !== nib; n++) @(posedge pclk);
		chk("latch", nib, port_q);
		apb(1, OFS_WAKE_EN, 32'h17f);
		cyc(HD1_LO);
		chk("masked", 1, low_power_mode);
		cyc(KBD_CMD);
		chk("kbd", 0, low_power_mode);
		chk("dflt", 4'hf, port_q);
		apb(1, OFS_CTRL, 1);
		for (n = 0; n < 99 && at_clk_async !== 0; n++) @(posedge pclk);
		chk("resume", 1, n > 9 && n < 21);
		apb(1, OFS_CTRL, 9);
		for (n = 0; n < 9 && mgmt_interrupt_req_n !== 0; n++) @(posedge pclk);
		chk("smi", 0, mgmt_interrupt_req_n);
		for (n = 0; n < 9 && mem_remap_smm !== 1; n++) @(posedge pclk);
		chk("flush", 0, cache_flush_n);
		rd = xs();
		nib = rd[3:0] & 4'h7;
		apb(1, OFS_PORT, {28'h0, nib});
		for (n = 0; n < 9 && port_q !== nib; n++) @(posedge pclk);
		chk("port", nib, port_q);
		irq_req <= 16'h8;
		@(posedge pclk) irq_req <= 0;
		for (n = 0; n < 9 && low_power_mode !== 0; n++) @(posedge pclk);
		chk("wake", 0, low_power_mode);
		soft_restart_req <= 1;
		@(posedge pclk) soft_restart_req <= 0;
		for (n = 0; n < 400 && soft_restart !== 1; n++) @(posedge pclk);
		chk("srst", 1, n >= SRST_CYC && n < SRST_CYC + 9);
		test_done;
	end
endmodule
